// ### bbr_addr_decode.sv
// Alias window decoder and bit-band target address generator
`timescale 1ns/1ps
module bbr_addr_decode
(
  // Incoming access
  input wire logic [31:0] addr_i,
  input wire logic [1:0] size_i,
  input wire logic instr_i,
  // Decode result
  output logic is_alias_o,
  output logic refuse_o,
  output logic [31:0] tgt_addr_o,
  output logic [4:0] bitpos_o
);

  logic in_sram_alias;
  logic in_peri_alias;
  logic [19:0] byte_off;
  logic [2:0] bit_num;
  logic [31:0] byte_addr;

  // SRAM band addresses miss the alias decode
  assign in_sram_alias =
    (addr_i & bbr_pkg::ALIAS_WIN_MASK) == bbr_pkg::SRAM_ALIAS_BASE;
  // peripheral band addresses miss the alias decode
  assign in_peri_alias =
    (addr_i & bbr_pkg::ALIAS_WIN_MASK) == bbr_pkg::PERI_ALIAS_BASE;

  // byte offset and bit number recovered from alias address
  assign byte_off = addr_i[bbr_pkg::BYTE_OFF_MSB:bbr_pkg::BYTE_OFF_LSB];
  // bit number 0..7 above the word offset
  assign bit_num = addr_i[bbr_pkg::BIT_NUM_MSB:bbr_pkg::BIT_NUM_LSB];

  // SRAM alias fetches fall through unremapped
  assign is_alias_o = (in_sram_alias || in_peri_alias) && !instr_i;
  assign refuse_o = in_peri_alias && instr_i;

  // one alias word lands on one byte of the 1-MB region
  assign byte_addr = (in_peri_alias ? bbr_pkg::PERI_BAND_BASE
                                    : bbr_pkg::SRAM_BAND_BASE)
                     | {12'h000, byte_off};

  // underlying access is aligned to the alias access size
  always_comb
  begin
    tgt_addr_o = byte_addr;
    if (size_i == bbr_pkg::SIZE_WORD)
    begin
      tgt_addr_o[1:0] = 2'h0;
    end
    else if (size_i == bbr_pkg::SIZE_HALF)
    begin
      tgt_addr_o[0] = 1'b0;
    end
  end

  // byte lane of the bus follows the low address bits
  assign bitpos_o = {byte_addr[1:0], bit_num};

endmodule

// ### bbr_bit_lane.sv
// Single-bit extract and insert on a little-endian 32-bit data bus
`timescale 1ns/1ps
module bbr_bit_lane
(
  // Data word and position
  input wire logic [31:0] word_i,
  input wire logic [4:0] bitpos_i,
  input wire logic new_bit_i,
  // Results
  output logic bit_o,
  output logic [31:0] merged_o
);

  // lane n carries the byte at address offset n
  assign bit_o = word_i[bitpos_i];

  // only the target bit changes, the rest is written back as read
  always_comb
  begin
    merged_o = word_i;
    merged_o[bitpos_i] = new_bit_i;
  end

endmodule

// ### bbr_mem_model.sv
// Memory and peripheral slave model on the remapper's downstream side
`timescale 1ns/1ps
module bbr_mem_model
(
  // Clock and test controls
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic err_i,
  // Command
  input wire logic mem_valid_i,
  input wire logic mem_write_i,
  input wire logic [1:0] mem_size_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  // Response
  output logic mem_ready_o = 1'b0,
  output logic mem_resp_o = 1'b0,
  output logic mem_err_o = 1'b0,
  output logic [31:0] mem_rdata_o = 32'h0
);
  logic [31:0] mem [logic [29:0]];
  logic [31:0] rd;
  logic [29:0] a;
  logic busy = 1'b0;
  int wait_c = 0;
  always @(posedge clk_i)
  begin
    mem_resp_o <= 1'b0;
    mem_err_o <= 1'b0;
    // Idle read data toggles so stale data never looks valid
    mem_rdata_o <= ~mem_rdata_o;
    if (busy)
    begin
      if (wait_c == 0)
      begin
        busy <= 1'b0;
        mem_resp_o <= 1'b1;
        mem_err_o <= err_i;
        mem_rdata_o <= rd;
        wait_c <= slow_i ? 2 : 0;
      end
      else
        wait_c <= wait_c - 1;
    end
    else if (mem_valid_i && mem_ready_o)
    begin
      mem_ready_o <= 1'b0;
      busy <= 1'b1;
      wait_c <= slow_i ? 3 : 0;
      a = mem_addr_i[31:2];
      if (!mem.exists(a))
        mem[a] = 32'h0;
      rd = mem[a];
      if (mem_write_i && !err_i)
        for (int n = 0; n < 4; n++)
          if (mem_size_i == 2'h2 || n[1:0] == mem_addr_i[1:0] ||
              (mem_size_i == 2'h1 && n[1] == mem_addr_i[1]))
            mem[a][8*n +: 8] = mem_wdata_i[8*n +: 8];
    end
    else if (mem_valid_i && wait_c > 0)
      wait_c <= wait_c - 1;
    else
      mem_ready_o <= mem_valid_i;
  end
endmodule

// ### bbr_pkg.sv
// Constants for the bit-band alias remapper
// Functional notes
// - Each 32-MB alias word controls exactly one bit of the 1-MB region.
// - Direct accesses to 0x2000_0000..0x2000_7fff pass as plain SRAM accesses.
// - SRAM alias data accesses are remapped; instruction fetches pass unremapped.
// - Direct accesses to 0x4000_0000..0x400f_ffff pass as plain peripheral accesses.
// - Peripheral alias data accesses are remapped; instruction fetches are refused.
// - Alias writes are done as read, single-bit change, then write-back.
// - Remapped access keeps the alias access size: word, halfword or byte.
// - Alias address equals alias base plus byte offset times 32 plus bit times 4.
// - Target bit number 0..7 comes from alias address bits above word offset.
// - Bit 0 of the alias write value is stored into the target bit.
// - Bits 31..1 of the alias write value have no effect.
// - Alias reads return 0x0000_0000 for clear and 0x0000_0001 for set.
// - Multi-byte data is little-endian, lowest byte at lowest address.
package bbr_pkg;

  localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_BAND_LAST = 32'h2000_7fff;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] SRAM_ALIAS_LAST = 32'h220f_ffff;
  localparam logic [31:0] PERI_BAND_BASE = 32'h4000_0000;
  localparam logic [31:0] PERI_BAND_LAST = 32'h400f_ffff;
  localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] PERI_ALIAS_LAST = 32'h43ff_ffff;

  // A 32-MB alias window is selected by address bits 31..25
  localparam logic [31:0] ALIAS_WIN_MASK = 32'hfe00_0000;
  // 1-MB byte offset sits in alias bits 24..5, bit number in 4..2
  localparam int BYTE_OFF_LSB = 5;
  localparam int BYTE_OFF_MSB = 24;
  localparam int BIT_NUM_LSB = 2;
  localparam int BIT_NUM_MSB = 4;
  localparam logic [31:0] ALIAS_STRIDE = 32'h0000_0020;
  localparam logic [31:0] BIT_STRIDE = 32'h0000_0004;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam logic [31:0] ALIAS_READ_CLR = 32'h0000_0000;
  localparam logic [31:0] ALIAS_READ_SET = 32'h0000_0001;

endpackage

// ### bbr_remapper.sv
// Bit-band alias remapper between a bus master and the memory bus
`timescale 1ns/1ps
module bbr_remapper
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Upstream request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_instr_i,
  input wire logic [1:0] req_size_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  output logic req_ready_o,
  // Upstream response
  output logic resp_valid_o,
  output logic resp_err_o,
  output logic [31:0] resp_rdata_o,
  // Downstream command
  output logic mem_valid_o,
  output logic mem_write_o,
  output logic [1:0] mem_size_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ready_i,
  // Downstream response
  input wire logic mem_resp_i,
  input wire logic mem_err_i,
  input wire logic [31:0] mem_rdata_i
);

  typedef enum logic [1:0] {
    BBR_IDLE,
    BBR_CMD,
    BBR_WAIT,
    BBR_RESP
  } bbr_state_t;

  typedef struct packed {
    bbr_state_t state;
    logic ready;
    logic resp_valid;
    logic resp_err;
    logic [31:0] resp_rdata;
    logic mem_valid;
    logic mem_write;
    logic [1:0] mem_size;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic is_alias;
    logic is_wr;
    logic [31:0] up_addr;
    logic [31:0] up_wdata;
    logic [4:0] bitpos;
    logic [31:0] rd_word;
  } bbr_regs_t;

  bbr_regs_t st_r;
  bbr_regs_t st_nxt;

  logic dec_alias;
  logic dec_refuse;
  logic [31:0] dec_addr;
  logic [4:0] dec_bitpos;
  logic lane_bit;
  logic [31:0] lane_merged;

  bbr_addr_decode u_decode
  (
    .addr_i(req_addr_i),
    .size_i(req_size_i),
    .instr_i(req_instr_i),
    .is_alias_o(dec_alias),
    .refuse_o(dec_refuse),
    .tgt_addr_o(dec_addr),
    .bitpos_o(dec_bitpos)
  );

  // the new bit value is bit 0 of the captured write data
  bbr_bit_lane u_lane
  (
    .word_i(mem_rdata_i),
    .bitpos_i(st_r.bitpos),
    .new_bit_i(st_r.up_wdata[0]),
    .bit_o(lane_bit),
    .merged_o(lane_merged)
  );

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r.state)
      BBR_IDLE:
      begin
        if (req_valid_i && st_r.ready)
        begin
          st_nxt.ready = 1'b0;
          st_nxt.is_alias = dec_alias;
          st_nxt.is_wr = req_write_i;
          st_nxt.up_addr = req_addr_i;
          st_nxt.up_wdata = req_wdata_i;
          st_nxt.bitpos = dec_bitpos;
          if (dec_refuse)
          begin
            // fetch from peripheral alias answers with an error
            st_nxt.resp_valid = 1'b1;
            st_nxt.resp_err = 1'b1;
            st_nxt.resp_rdata = bbr_pkg::ALIAS_READ_CLR;
            st_nxt.state = BBR_RESP;
          end
          else
          begin
            st_nxt.mem_valid = 1'b1;
            // size passes through in both paths
            st_nxt.mem_size = req_size_i;
            if (dec_alias)
            begin
              // alias access always begins with a read
              st_nxt.mem_write = 1'b0;
              st_nxt.mem_addr = dec_addr;
              st_nxt.mem_wdata = req_wdata_i;
            end
            else
            begin
              // address, size and data forwarded untouched
              st_nxt.mem_write = req_write_i;
              st_nxt.mem_addr = req_addr_i;
              st_nxt.mem_wdata = req_wdata_i;
            end
            st_nxt.state = BBR_CMD;
          end
        end
      end
      BBR_CMD:
      begin
        if (mem_ready_i)
        begin
          st_nxt.mem_valid = 1'b0;
          st_nxt.state = BBR_WAIT;
        end
      end
      BBR_WAIT:
      begin
        if (mem_resp_i)
        begin
          if (mem_err_i)
          begin
            st_nxt.resp_valid = 1'b1;
            st_nxt.resp_err = 1'b1;
            st_nxt.resp_rdata = bbr_pkg::ALIAS_READ_CLR;
            st_nxt.state = BBR_RESP;
          end
          else if (st_r.is_alias && st_r.is_wr && !st_r.mem_write)
          begin
            // write back the read word with one bit changed
            // upper write bits never reach the merged word
            st_nxt.rd_word = mem_rdata_i;
            st_nxt.mem_valid = 1'b1;
            st_nxt.mem_write = 1'b1;
            st_nxt.mem_wdata = lane_merged;
            st_nxt.state = BBR_CMD;
          end
          else
          begin
            st_nxt.resp_valid = 1'b1;
            st_nxt.resp_err = 1'b0;
            if (st_r.is_wr)
            begin
              st_nxt.resp_rdata = bbr_pkg::ALIAS_READ_CLR;
            end
            else if (st_r.is_alias)
            begin
              // alias read returns 0 or 1 only
              st_nxt.resp_rdata = lane_bit ? bbr_pkg::ALIAS_READ_SET
                                           : bbr_pkg::ALIAS_READ_CLR;
            end
            else
            begin
              st_nxt.resp_rdata = mem_rdata_i;
            end
            st_nxt.state = BBR_RESP;
          end
        end
      end
      BBR_RESP:
      begin
        st_nxt.resp_valid = 1'b0;
        st_nxt.resp_err = 1'b0;
        st_nxt.ready = 1'b1;
        st_nxt.state = BBR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_r <= '{state: BBR_IDLE, ready: 1'b1, resp_valid: 1'b0,
                resp_err: 1'b0, resp_rdata: 32'h0000_0000,
                mem_valid: 1'b0, mem_write: 1'b0, mem_size: 2'h0,
                mem_addr: 32'h0000_0000, mem_wdata: 32'h0000_0000,
                is_alias: 1'b0, is_wr: 1'b0, up_addr: 32'h0000_0000,
                up_wdata: 32'h0000_0000, bitpos: 5'h00,
                rd_word: 32'h0000_0000};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign req_ready_o = st_r.ready;
  assign resp_valid_o = st_r.resp_valid;
  assign resp_err_o = st_r.resp_err;
  assign resp_rdata_o = st_r.resp_rdata;
  assign mem_valid_o = st_r.mem_valid;
  assign mem_write_o = st_r.mem_write;
  assign mem_size_o = st_r.mem_size;
  assign mem_addr_o = st_r.mem_addr;
  assign mem_wdata_o = st_r.mem_wdata;

  // Checks: helper values rebuild the alias address from target address, bit position and window
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic [31:0] chk_band;
  logic [31:0] chk_alias;
  logic [31:0] chk_byte;
  assign chk_band = (st_r.up_addr[30]) ? bbr_pkg::PERI_BAND_BASE
                                       : bbr_pkg::SRAM_BAND_BASE;
  assign chk_byte = chk_band
    | {12'h000, st_r.mem_addr[19:2], st_r.bitpos[4:3]};
  assign chk_alias = (st_r.up_addr & bbr_pkg::ALIAS_WIN_MASK)
    + (chk_byte - chk_band) * bbr_pkg::ALIAS_STRIDE
    + {29'h0, st_r.bitpos[2:0]} * bbr_pkg::BIT_STRIDE;

  sequence s_alias_read_done;
    mem_resp_i && !mem_err_i && st_r.is_alias && st_r.is_wr
      && !st_r.mem_write && st_r.state == BBR_WAIT;
  endsequence

  sequence s_writeback_issued;
    mem_valid_o && mem_write_o;
  endsequence

  // formula rebuilds the word-aligned alias address
  a_alias_addr_formula: assert property (
    mem_valid_o && st_r.is_alias |->
      chk_alias[31:2] == st_r.up_addr[31:2])
    else $error("alias address does not match bit-band target");

  // pass-through keeps address, data and write direction
  a_direct_pass_through: assert property (
    mem_valid_o && !st_r.is_alias |->
      mem_addr_o == st_r.up_addr && mem_wdata_o == st_r.up_wdata
      && mem_write_o == st_r.is_wr)
    else $error("direct access altered on its way downstream");

  // downstream size equals the upstream size
  a_size_kept_same: assert property (
    req_valid_i && req_ready_o && !dec_refuse |=>
      mem_valid_o && mem_size_o == $past(req_size_i))
    else $error("downstream size differs from request size");

  // alias write read is followed by a write-back
  a_rmw_writeback_follows: assert property (
    s_alias_read_done |=> s_writeback_issued
      and (mem_addr_o == $past(mem_addr_o)))
    else $error("alias write lacks write-back to same location");

  // written back bit equals bit 0 of the write value
  a_write_bit_zero: assert property (
    mem_valid_o && mem_write_o && st_r.is_alias |->
      mem_wdata_o[st_r.bitpos] == st_r.up_wdata[0])
    else $error("target bit not taken from write data bit 0");

  // write-back differs from read word in the target bit only
  a_single_bit_change: assert property (
    mem_valid_o && mem_write_o && st_r.is_alias |->
      (mem_wdata_o ^ st_r.rd_word) == 32'h0000_0000
      || (mem_wdata_o ^ st_r.rd_word) == (32'h0000_0001 << st_r.bitpos))
    else $error("write-back changed more than the target bit");

  // alias read answer is 0 or 1
  a_alias_read_value: assert property (
    resp_valid_o && !resp_err_o && st_r.is_alias && !st_r.is_wr |->
      resp_rdata_o[31:1] == 31'h0000_0000)
    else $error("alias read returned bits above bit 0");

  // peripheral alias fetch answered with error, no bus access
  a_fetch_refused_err: assert property (
    req_valid_i && req_ready_o && dec_refuse |=>
      resp_valid_o && resp_err_o && !mem_valid_o ##1 !resp_valid_o)
    else $error("peripheral alias fetch was not refused");

  // SRAM alias fetch goes out at its own address
  a_sram_fetch_direct: assert property (
    req_valid_i && req_ready_o && req_instr_i
      && (req_addr_i & bbr_pkg::ALIAS_WIN_MASK) == bbr_pkg::SRAM_ALIAS_BASE
      |=> mem_valid_o && mem_addr_o == $past(req_addr_i))
    else $error("SRAM alias fetch was remapped");

endmodule

// ### bbr_remapper_test.sv
// Self-checking bench for the bit-band alias remapper
`timescale 1ns/1ps
module bbr_remapper_test;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic req_instr_i = 1'b0;
  logic [1:0] req_size_i = 2'h0;
  logic [31:0] req_addr_i = 32'h0;
  logic [31:0] req_wdata_i = 32'h0;
  logic slow = 1'b0;
  logic merr = 1'b0;
  logic req_ready_o, resp_valid_o, resp_err_o, mem_valid_o, mem_write_o;
  logic mem_ready, mem_resp, mem_err;
  logic [1:0] mem_size_o;
  logic [31:0] resp_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata;
  logic [31:0] qa[$];
  logic [31:0] qd[$];
  logic [1:0] qs[$];
  logic qw[$];
  logic [31:0] rdv;
  logic erv;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #50 clk_i = ~clk_i;

  bbr_remapper bbr_remapper_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_instr_i(req_instr_i), .req_size_i(req_size_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o),
    .resp_err_o(resp_err_o), .resp_rdata_o(resp_rdata_o),
    .mem_valid_o(mem_valid_o), .mem_write_o(mem_write_o),
    .mem_size_o(mem_size_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ready_i(mem_ready),
    .mem_resp_i(mem_resp), .mem_err_i(mem_err), .mem_rdata_i(mem_rdata));

  bbr_mem_model bbr_mem_model_inst (.clk_i(clk_i), .slow_i(slow),
    .err_i(merr), .mem_valid_i(mem_valid_o), .mem_write_i(mem_write_o),
    .mem_size_i(mem_size_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ready_o(mem_ready),
    .mem_resp_o(mem_resp), .mem_err_o(mem_err), .mem_rdata_o(mem_rdata));

  // Log every downstream command taken
  always @(posedge clk_i)
  begin
    if (mem_valid_o === 1'b1 && mem_ready === 1'b1)
    begin
      qa.push_back(mem_addr_o);
      qd.push_back(mem_wdata_o);
      qs.push_back(mem_size_o);
      qw.push_back(mem_write_o);
    end
  end

  task automatic stop_test();
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One upstream access: held until taken, then wait for the answer
  task automatic acc(input logic w, input logic ins, input logic [1:0] sz,
                     input logic [31:0] a, input logic [31:0] d);
    int n;
    qa.delete();
    qd.delete();
    qs.delete();
    qw.delete();
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_instr_i <= ins;
    req_size_i <= sz;
    req_addr_i <= a;
    req_wdata_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (req_ready_o !== 1'b1 && n < 50);
    if (n >= 50)
      failures++;
    req_valid_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (resp_valid_o !== 1'b1 && n < 200);
    if (n >= 200)
      failures++;
    rdv = resp_rdata_o;
    erv = resp_err_o;
  endtask

  task automatic t_direct();
    acc(1'b1, 1'b0, 2'h2, 32'h2000_7ffc, 32'h1234_5678);
    chk("sram addr", qa[0], 32'h2000_7ffc);
    chk("sram data", qd[0], 32'h1234_5678);
    chk("sram err", erv, 32'h0);
    acc(1'b0, 1'b0, 2'h2, 32'h2000_7ffc, 32'h0);
    chk("sram read", rdv, 32'h1234_5678);
    acc(1'b1, 1'b0, 2'h0, 32'h400f_ffff, 32'hab00_0000);
    chk("peri addr", qa[0], 32'h400f_ffff);
    chk("peri size", qs[0], 32'h0);
    acc(1'b0, 1'b0, 2'h1, 32'h6000_0002, 32'h0);
    chk("other addr", qa[0], 32'h6000_0002);
    chk("other size", qs[0], 32'h1);
  endtask

  task automatic t_sram_alias();
    acc(1'b1, 1'b0, 2'h2, 32'h2000_0100, 32'h0);
    for (int b = 0; b < 8; b++)
    begin
      acc(1'b1, 1'b0, 2'h2, 32'h2200_2060 + 32'(b * 4),
          b[0] ? 32'hffff_fffe : 32'h0000_0003);
      chk("rmw count", qa.size(), 32'h2);
      chk("rmw order", {qw[0], qw[1]}, 32'h1);
      chk("rmw addr", qa[1], 32'h2000_0100);
      chk("rmw size", qs[1], 32'h2);
      if (b == 0)
        chk("rmw data", qd[1], 32'h0100_0000);
    end
    acc(1'b0, 1'b0, 2'h2, 32'h2000_0100, 32'h0);
    chk("band word", rdv, 32'h5500_0000);
    for (int b = 0; b < 8; b++)
    begin
      acc(1'b0, 1'b0, 2'h2, 32'h2200_2060 + 32'(b * 4), 32'h0);
      chk("alias read", rdv, b[0] ? 32'h0 : 32'h1);
    end
  endtask

  task automatic t_peri_alias();
    slow <= 1'b1;
    acc(1'b1, 1'b0, 2'h2, 32'h43ff_fffc, 32'hffff_fffe);
    chk("peri rmw", qa[1], 32'h400f_fffc);
    slow <= 1'b0;
    acc(1'b0, 1'b0, 2'h2, 32'h400f_fffc, 32'h0);
    chk("peri bit7", rdv, 32'h2b00_0000);
    acc(1'b0, 1'b1, 2'h2, 32'h4200_0000, 32'h0);
    chk("fetch err", erv, 32'h1);
    chk("fetch cmds", qa.size(), 32'h0);
    acc(1'b0, 1'b1, 2'h2, 32'h2200_0004, 32'h0);
    chk("sram fetch", qa[0], 32'h2200_0004);
  endtask

  task automatic t_sizes();
    acc(1'b1, 1'b0, 2'h0, 32'h2200_402c, 32'h1);
    chk("byte addr", qa[1], 32'h2000_0201);
    chk("byte size", qs[1], 32'h0);
    chk("byte data", qd[1], 32'h0000_0800);
    acc(1'b0, 1'b0, 2'h1, 32'h2200_402c, 32'h0);
    chk("half size", qs[0], 32'h1);
    chk("half read", rdv, 32'h1);
    acc(1'b0, 1'b0, 2'h2, 32'h2000_0200, 32'h0);
    chk("byte word", rdv, 32'h0000_0800);
  endtask

  task automatic t_error();
    merr <= 1'b1;
    acc(1'b1, 1'b0, 2'h2, 32'h2200_0000, 32'h1);
    merr <= 1'b0;
    chk("err resp", erv, 32'h1);
    chk("err cmds", qa.size(), 32'h1);
    acc(1'b0, 1'b0, 2'h2, 32'h2000_0000, 32'h0);
    chk("err kept", rdv, 32'h0);
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    #1;
    chk("reset ready", req_ready_o, 32'h1);
    chk("reset mem", mem_valid_o, 32'h0);
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_direct();
    t_sram_alias();
    t_peri_alias();
    t_sizes();
    t_error();
    stop_test();
  end
endmodule
